// ### include/hbt_if.sv
`timescale 1ns/1ns
// Link between drive and controller; words are level signals
interface hbt_if;
    logic [15:0] cmd_word;     // Drive command word, controller drives
    logic [7:0]  mode_sel;     // Mode override selector, controller drives
    logic [15:0] state_word;   // Drive state word, drive drives
    logic [7:0]  resume_idx;   // Resumable block index, drive drives

    modport drive (
        input  cmd_word,
        input  mode_sel,
        output state_word,
        output resume_idx
    );

    modport ctrl (
        output cmd_word,
        output mode_sel,
        input  state_word,
        input  resume_idx
    );
endinterface

// ### include/hbt_pkg.sv
package hbt_pkg;

    // ------------------------------------------------------------
    // Modes, command word and state word layout
    // ------------------------------------------------------------
    localparam logic [7:0]  MODE_HOMING      = 8'h06;  // Homing selector value
    localparam logic [7:0]  MODE_TABLE       = 8'h07;  // Table travel selector value
    localparam int          CW_BIT_START     = 4;      // Homing start / sequence mode
    localparam int          CW_BIT_RESUME    = 6;      // Resume last block
    localparam int          CW_BIT_HALT      = 8;      // Halt
    localparam int          CW_BIT_BLKSTART  = 9;      // Start motion block
    localparam int          CW_SEL_LSB       = 11;     // Block select field low bit
    localparam int          SW_BIT_INPROG    = 8;      // Block in progress
    localparam int          SW_BIT_TARGET    = 10;     // Target reached
    localparam int          SW_BIT_ATTAIN    = 12;     // Homing attained
    localparam int          SW_BIT_HERR      = 13;     // Homing error

    // ------------------------------------------------------------
    // Enable sequence command and state words
    // ------------------------------------------------------------
    localparam logic [15:0] CW_DISABLE       = 16'h0000;
    localparam logic [15:0] CW_SHUTDOWN      = 16'h0006;
    localparam logic [15:0] CW_SWITCH_ON     = 16'h0007;
    localparam logic [15:0] CW_ENABLE        = 16'h000f;
    localparam logic [15:0] CW_HOMING_GO     = 16'h001f;
    localparam logic [15:0] SW_DISABLED      = 16'h0050;
    localparam logic [15:0] SW_READY         = 16'h0031;
    localparam logic [15:0] SW_SWITCHED_ON   = 16'h0033;
    localparam logic [7:0]  SW_ENABLED_LO    = 8'h37;
    localparam logic [3:0]  CW_ENABLE_NIB    = 4'hf;

    // ------------------------------------------------------------
    // Host register map (word index = byte address / 4)
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_CMD          = 4'h0;   // Command word to send
    localparam logic [3:0]  REG_MODE         = 4'h1;   // Mode selector to send
    localparam logic [3:0]  REG_STATE        = 4'h2;   // Last state word seen
    localparam logic [3:0]  REG_IRQ_STAT     = 4'h3;   // Sticky events, write 1 clears
    localparam logic [3:0]  REG_IRQ_MASK     = 4'h4;   // Event enables
    localparam logic [3:0]  REG_RESUME       = 4'h5;   // Resumable block index seen
    localparam logic [3:0]  REG_CTRL         = 4'h6;   // Bit0 = run enable sequence
    localparam logic [15:0] RESET_WORD       = 16'h0000;
    localparam logic [7:0]  NO_RESUME        = 8'hff;  // -1: nothing to resume

    // ------------------------------------------------------------
    // Motion model timing in cycles (25 MHz)
    // ------------------------------------------------------------
    localparam logic [7:0]  MOVE_CYCLES      = 8'h20;  // Per block / homing run
    localparam logic [7:0]  STOP_CYCLES      = 8'h08;  // Ramp down to speed 0

    // Device power state
    typedef enum logic [1:0] {
        HBT_PS_DISABLED = 2'b00,
        HBT_PS_READY    = 2'b01,
        HBT_PS_ON       = 2'b10,
        HBT_PS_ENABLED  = 2'b11
    } hbt_pstate_e;

    // Host sequencer step
    typedef enum logic [2:0] {
        HBT_HS_IDLE  = 3'b000,
        HBT_HS_DIS   = 3'b001,
        HBT_HS_SHUT  = 3'b010,
        HBT_HS_SWON  = 3'b011,
        HBT_HS_DONE  = 3'b100
    } hbt_hstep_e;

endpackage

// ### rtl/hbt_ctrl.sv
`timescale 1ns/1ns
module hbt_ctrl (
    input  wire logic        clk_i,       // 25 MHz clock
    input  wire logic        rst_i,       // Async reset, active high
    input  wire logic        ce_i,        // Clock enable
    input  wire logic [3:0]  addr_i,      // Register index
    input  wire logic [15:0] wdata_i,     // Write data
    input  wire logic        wr_i,        // Write strobe
    input  wire logic        rd_i,        // Read strobe
    output logic      [15:0] rdata_o,     // Read data, cycle after strobe
    output logic             irq_o,       // Level interrupt
    hbt_if.ctrl              lnk
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        hbt_pkg::hbt_hstep_e step;   // Enable sequence step
        logic [15:0] cmd;            // Command word driven
        logic [7:0]  mode;           // Mode selector driven
        logic [15:0] sw_seen;        // Previous state word
        logic [2:0]  stat;           // Events: seq done, attained, block done
        logic [2:0]  mask;           // Event enables
        logic [15:0] rdata;          // Read data
        logic        irq;            // Interrupt output
    } hbt_ctl_s;

    hbt_ctl_s st_reg;
    hbt_ctl_s st_next;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [2:0] ev;
        logic       switched_on;
        st_next = st_reg;
        switched_on = (lnk.state_word[7:0] == hbt_pkg::SW_SWITCHED_ON[7:0]);
        st_next.sw_seen = lnk.state_word;
        ev = 3'b000;

        // Enable sequence: 0000, 0006, 0007 awaiting each answer
        case (st_reg.step)
            hbt_pkg::HBT_HS_IDLE: ;
            hbt_pkg::HBT_HS_DIS:
                if (lnk.state_word == hbt_pkg::SW_DISABLED)
                begin
                    st_next.cmd  = hbt_pkg::CW_SHUTDOWN;       // [RULE7]
                    st_next.step = hbt_pkg::HBT_HS_SHUT;
                end
            hbt_pkg::HBT_HS_SHUT:
                if (lnk.state_word == hbt_pkg::SW_READY)
                begin
                    st_next.cmd  = hbt_pkg::CW_SWITCH_ON;      // [RULE7]
                    st_next.step = hbt_pkg::HBT_HS_SWON;
                end
            hbt_pkg::HBT_HS_SWON:
                if (lnk.state_word == hbt_pkg::SW_SWITCHED_ON)
                begin
                    st_next.step = hbt_pkg::HBT_HS_DONE;
                    ev[0] = 1'b1;
                end
            hbt_pkg::HBT_HS_DONE: ;
            default: st_next.step = hbt_pkg::HBT_HS_IDLE;
        endcase

        // Events from state word edges
        if (lnk.state_word[hbt_pkg::SW_BIT_ATTAIN] && !st_reg.sw_seen[hbt_pkg::SW_BIT_ATTAIN])
            ev[1] = 1'b1;                                      // [RULE9]
        if (!lnk.state_word[hbt_pkg::SW_BIT_INPROG] && st_reg.sw_seen[hbt_pkg::SW_BIT_INPROG])
            ev[2] = 1'b1;

        // Register writes
        st_next.rdata = 16'h0000;
        if (wr_i)
        begin
            case (addr_i)
                hbt_pkg::REG_CMD:  st_next.cmd = wdata_i;
                hbt_pkg::REG_MODE:
                    // Mode changes only while switched on
                    if (switched_on)
                        st_next.mode = wdata_i[7:0];           // [RULE10] [RULE11]
                hbt_pkg::REG_IRQ_STAT: st_next.stat = st_reg.stat & ~wdata_i[2:0];
                hbt_pkg::REG_IRQ_MASK: st_next.mask = wdata_i[2:0];
                hbt_pkg::REG_CTRL:
                    if (wdata_i[0])
                    begin
                        st_next.cmd  = hbt_pkg::CW_DISABLE;    // [RULE7]
                        st_next.step = hbt_pkg::HBT_HS_DIS;
                    end
                default: ;
            endcase
        end
        // Set wins over clear
        st_next.stat = st_next.stat | ev;

        // Register reads
        if (rd_i)
        begin
            case (addr_i)
                hbt_pkg::REG_CMD:      st_next.rdata = st_reg.cmd;
                hbt_pkg::REG_MODE:     st_next.rdata = {8'h00, st_reg.mode};
                hbt_pkg::REG_STATE:    st_next.rdata = lnk.state_word;
                hbt_pkg::REG_IRQ_STAT: st_next.rdata = {13'h0000, st_reg.stat};
                hbt_pkg::REG_IRQ_MASK: st_next.rdata = {13'h0000, st_reg.mask};
                hbt_pkg::REG_RESUME:   st_next.rdata = {8'h00, lnk.resume_idx};
                hbt_pkg::REG_CTRL:     st_next.rdata = {13'h0000, st_reg.step};
                default:               st_next.rdata = 16'h0000;
            endcase
        end
        st_next.irq = |(st_next.stat & st_next.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_reg <= '0;
        else if (ce_i)
            st_reg <= st_next;
    end

    assign lnk.cmd_word = st_reg.cmd;
    assign lnk.mode_sel = st_reg.mode;
    assign rdata_o      = st_reg.rdata;
    assign irq_o        = st_reg.irq;

endmodule

// ### rtl/hbt_drive.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// RULE1: Homing selector value runs a reference run
// RULE2: Bit 4 rise starts homing, fall stops
// RULE3: Bit 8 halts homing, stay enabled
// RULE4: Status 10: home reached or zero speed
// RULE5: Status 12 set once homing completes
// RULE6: Homing error flag on failed homing
// RULE7: 0000/0006/0007 answered 0050/0031/0033
// RULE8: Low nibble F enables; motion only then
// RULE9: 001F starts homing, success gives 1n37
// RULE10: Controller changes mode only at 0007
// RULE11: Controller checks switched-on before mode change
// RULE12: Bit 4 picks single block or sequence
// RULE13: Bit 6 resumes last block, index readable
// RULE14: Bit 8 halts block on its ramp
// RULE15: Bit 9 rise runs blocks, low stops
// RULE16: Select field n gives start block n+1
// RULE17: Status 8 high while blocks execute
// RULE18: Sequence ends at next-block 0,-1,-2,-3
// RULE19: Edges from previous versus new command word
module hbt_drive (
    input  wire logic        clk_i,          // 25 MHz clock
    input  wire logic        rst_i,          // Async reset, active high
    input  wire logic        ce_i,           // Clock enable, freezes all state
    input  wire logic        home_fail_i,    // Homing run fails (e.g. switch missing)
    input  wire logic [7:0]  next_block_i,   // Next-block setting of current block
    output logic      [4:0]  act_block_o,    // Block now executing (0 based)
    output logic             moving_o,       // Axis in motion
    hbt_if.drive             lnk
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        hbt_pkg::hbt_pstate_e pst;      // Power state
        logic [15:0] prev_cmd;          // Previous command word for edges
        logic [15:0] sw;                // State word out
        logic [7:0]  resume;            // Resumable index out
        logic        homing;            // Homing run active
        logic        attained;          // Homing completed
        logic        herr;              // Homing error
        logic        running;           // Blocks executing
        logic        halted;            // Halt or stop ramp in progress
        logic        auto_seq;          // Sequence mode latched at start
        logic [4:0]  blk;               // Current block
        logic [7:0]  tmr;               // Motion / ramp timer
        logic        target;            // Target reached or speed 0
        logic        moving;            // Axis moving
    } hbt_drv_s;

    hbt_drv_s st_reg;     // Registered state
    hbt_drv_s st_next;    // Next state

    // Sequence end test: next setting 0, -1, -2 or -3
    function automatic logic seq_end(input logic [7:0] nb);
        seq_end = (nb == 8'h00) || (nb == 8'hff) || (nb == 8'hfe) || (nb == 8'hfd);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [15:0] cw;
        logic [15:0] rise;
        logic [15:0] fall;
        logic        en_cmd;
        logic        halt;
        cw     = lnk.cmd_word;
        rise   = cw & ~st_reg.prev_cmd;                        // [RULE19]
        fall   = ~cw & st_reg.prev_cmd;                        // [RULE19]
        en_cmd = (cw[3:0] == hbt_pkg::CW_ENABLE_NIB);
        halt   = cw[hbt_pkg::CW_BIT_HALT];
        st_next = st_reg;
        st_next.prev_cmd = cw;

        // Power state follows the command word
        if (en_cmd && st_reg.pst != hbt_pkg::HBT_PS_DISABLED)
            st_next.pst = hbt_pkg::HBT_PS_ENABLED;             // [RULE8]
        else if (cw == hbt_pkg::CW_SWITCH_ON && st_reg.pst != hbt_pkg::HBT_PS_DISABLED)
            st_next.pst = hbt_pkg::HBT_PS_ON;                  // [RULE7]
        else if (cw == hbt_pkg::CW_SHUTDOWN)
            st_next.pst = hbt_pkg::HBT_PS_READY;               // [RULE7]
        else if (!en_cmd)
            st_next.pst = hbt_pkg::HBT_PS_DISABLED;            // [RULE7]

        // Timer counts down while nonzero
        if (st_reg.tmr != 8'h00)
            st_next.tmr = st_reg.tmr - 8'h01;

        if (st_next.pst != hbt_pkg::HBT_PS_ENABLED)
        begin
            // Motion only in enabled state; drop homing, running, halt, moving and timer
            st_next.homing  = 1'b0;                            // [RULE8]
            st_next.running = 1'b0;
            st_next.halted  = 1'b0;
            st_next.moving  = 1'b0;
            st_next.tmr     = 8'h00;
        end
        else if (lnk.mode_sel == hbt_pkg::MODE_HOMING)
        begin
            if (halt)
            begin
                // Decelerate with homing ramp, stay enabled
                if (!st_reg.halted)
                begin
                    st_next.halted = 1'b1;                     // [RULE3]
                    st_next.tmr    = hbt_pkg::STOP_CYCLES;
                end
                else if (st_reg.tmr == 8'h00)
                    st_next.moving = 1'b0;                     // [RULE3]
            end
            else
            begin
                st_next.halted = 1'b0;
                if (rise[hbt_pkg::CW_BIT_START])
                begin
                    // Fresh reference run
                    st_next.homing   = 1'b1;                   // [RULE1] [RULE2] [RULE9]
                    st_next.attained = 1'b0;
                    st_next.herr     = 1'b0;
                    st_next.moving   = 1'b1;
                    st_next.tmr      = hbt_pkg::MOVE_CYCLES;
                end
                else if (fall[hbt_pkg::CW_BIT_START])
                begin
                    st_next.homing = 1'b0;                     // [RULE2]
                    st_next.moving = 1'b0;
                end
                else if (st_reg.halted && st_reg.homing)
                begin
                    // Halt released mid-run: home not found yet, so run on
                    st_next.moving = 1'b1;                     // [RULE3]
                    st_next.tmr    = hbt_pkg::MOVE_CYCLES;
                end
                else if (st_reg.homing && home_fail_i)
                begin
                    st_next.homing = 1'b0;                     // [RULE6]
                    st_next.herr   = 1'b1;
                    st_next.moving = 1'b0;
                end
                else if (st_reg.homing && st_reg.tmr == 8'h00)
                begin
                    st_next.homing   = 1'b0;                   // [RULE5]
                    st_next.attained = 1'b1;
                    st_next.moving   = 1'b0;
                end
            end
            // Home reached when not halted, speed 0 when halted
            st_next.target = halt ? !st_next.moving : st_next.attained;  // [RULE4]
        end
        else if (lnk.mode_sel == hbt_pkg::MODE_TABLE)
        begin
            if (rise[hbt_pkg::CW_BIT_BLKSTART] && !halt)
            begin
                // Pick start block: resume or selection field
                if (cw[hbt_pkg::CW_BIT_RESUME] && st_reg.resume != hbt_pkg::NO_RESUME)
                    st_next.blk = st_reg.resume[4:0];          // [RULE13]
                else
                    st_next.blk = cw[hbt_pkg::CW_SEL_LSB +: 5]; // Block n+1, 0 based [RULE16]
                st_next.auto_seq = cw[hbt_pkg::CW_BIT_START];  // [RULE12]
                st_next.running  = 1'b1;                       // [RULE15] [RULE17]
                st_next.halted   = 1'b0;
                st_next.moving   = 1'b1;
                st_next.target   = 1'b0;
                st_next.resume   = hbt_pkg::NO_RESUME;
                st_next.tmr      = hbt_pkg::MOVE_CYCLES;
            end
            else if (st_reg.running && (halt || !cw[hbt_pkg::CW_BIT_BLKSTART]))
            begin
                // Stop on current block's ramp, remember it when bit 9 drops
                if (!st_reg.halted)
                begin
                    st_next.halted = 1'b1;                     // [RULE14] [RULE15]
                    st_next.tmr    = hbt_pkg::STOP_CYCLES;
                end
                else if (st_reg.tmr == 8'h00)
                begin
                    st_next.moving = 1'b0;
                    st_next.target = halt;                     // Speed 0 under halt
                    if (!cw[hbt_pkg::CW_BIT_BLKSTART])
                    begin
                        st_next.running = 1'b0;                // Interrupted
                        st_next.resume  = {3'b000, st_reg.blk};  // [RULE13]
                    end
                end
            end
            else if (st_reg.running && st_reg.halted)
            begin
                // Halt released: continue the block
                st_next.halted = 1'b0;
                st_next.moving = 1'b1;
                st_next.target = 1'b0;
                st_next.tmr    = hbt_pkg::MOVE_CYCLES;
            end
            else if (st_reg.running && st_reg.tmr == 8'h00)
            begin
                if (st_reg.auto_seq && !seq_end(next_block_i))
                begin
                    st_next.blk = next_block_i[4:0] - 5'h01;   // Next block, 0 based
                    st_next.tmr = hbt_pkg::MOVE_CYCLES;
                end
                else
                begin
                    st_next.running = 1'b0;                    // [RULE17] [RULE18]
                    st_next.moving  = 1'b0;
                    st_next.target  = 1'b1;
                end
            end
        end

        // Assemble state word from power state and mode bits
        case (st_next.pst)
            hbt_pkg::HBT_PS_DISABLED: st_next.sw = hbt_pkg::SW_DISABLED;     // [RULE7]
            hbt_pkg::HBT_PS_READY:    st_next.sw = hbt_pkg::SW_READY;
            hbt_pkg::HBT_PS_ON:       st_next.sw = hbt_pkg::SW_SWITCHED_ON;
            hbt_pkg::HBT_PS_ENABLED:  st_next.sw = {8'h00, hbt_pkg::SW_ENABLED_LO};
            default:                  st_next.sw = hbt_pkg::SW_DISABLED;
        endcase
        if (st_next.pst == hbt_pkg::HBT_PS_ENABLED)
        begin
            st_next.sw[hbt_pkg::SW_BIT_TARGET] = st_next.target;
            if (lnk.mode_sel == hbt_pkg::MODE_HOMING)
            begin
                st_next.sw[hbt_pkg::SW_BIT_ATTAIN] = st_next.attained;  // [RULE5] [RULE9]
                st_next.sw[hbt_pkg::SW_BIT_HERR]   = st_next.herr;      // [RULE6]
            end
            else if (lnk.mode_sel == hbt_pkg::MODE_TABLE)
                st_next.sw[hbt_pkg::SW_BIT_INPROG] = st_next.running;   // [RULE17]
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg          <= '0;
            st_reg.sw       <= hbt_pkg::SW_DISABLED;
            st_reg.resume   <= hbt_pkg::NO_RESUME;
        end
        else if (ce_i)
            st_reg <= st_next;
    end

    assign lnk.state_word = st_reg.sw;
    assign lnk.resume_idx = st_reg.resume;
    assign act_block_o    = st_reg.blk;
    assign moving_o       = st_reg.moving;

endmodule

// ### tb/hbt_props.sv
`timescale 1ns/1ns
// Link checker: ties each state word answer to the command that caused it
module hbt_props (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] cmd_word,
    input  wire logic [7:0]  mode_sel,
    input  wire logic [15:0] state_word,
    input  wire logic [7:0]  resume_idx
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_disable_ans: assert property (cmd_word == 16'h0000 |=> state_word == 16'h0050)
        else $error("disable answer wrong");
    a_ready_ans: assert property (cmd_word == 16'h0006 |=> state_word == 16'h0031)
        else $error("ready answer wrong");
    a_swon_ans: assert property ((cmd_word == 16'h0007) && (state_word != 16'h0050)
        |=> state_word == 16'h0033) else $error("switched on answer wrong");
    a_enable_ans: assert property ((cmd_word[3:0] == 4'hf) && (state_word != 16'h0050)
        |=> state_word[7:0] == 8'h37) else $error("enabled answer wrong");
    a_home_cause: assert property ($rose(state_word[12]) |-> mode_sel == 8'h06 && cmd_word[4])
        else $error("homing attained without run");
    a_herr_mode: assert property ($rose(state_word[13]) |-> mode_sel == 8'h06)
        else $error("homing error outside homing");
    a_block_start: assert property ($rose(state_word[8]) |-> mode_sel == 8'h07 && cmd_word[9])
        else $error("block started without start bit");
    a_block_stop: assert property ($fell(cmd_word[9]) && state_word[8]
        |-> ##[1:12] !state_word[8]) else $error("block not stopped");
    a_mode_gate: assert property ($changed(mode_sel) |-> $past(state_word[7:0]) == 8'h33)
        else $error("mode changed outside switched on");
    a_resume_set: assert property ($rose(resume_idx != 8'hff) |-> !cmd_word[9])
        else $error("resume index set while running");
endmodule

// ### tb/homing_and_block_travel_ctrl_tb.sv
`timescale 1ns/1ns
module homing_and_block_travel_ctrl_tb;
    logic        clk_i = 1'b0;      // 25 MHz clock
    logic        rst_i = 1'b1;      // Held for 16 cycles
    logic        ce_i = 1'b1;       // Clock enable for both ends
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        home_fail_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] rdata_o;
    logic [15:0] rd_v;
    logic [7:0]  next_block_i = 8'h00;
    logic [4:0]  act_block_o;
    logic        irq_o;
    logic        moving_o;
    int          n_fail = 0;
    int          num_checks = 0;
    hbt_if lnk ();
    hbt_drive u_hbt_drive (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .home_fail_i(home_fail_i),
        .next_block_i(next_block_i), .act_block_o(act_block_o), .moving_o(moving_o), .lnk(lnk));
    hbt_ctrl u_hbt_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .lnk(lnk));
    hbt_props u_hbt_props (.clk_i(clk_i), .rst_i(rst_i), .cmd_word(lnk.cmd_word),
        .mode_sel(lnk.mode_sel), .state_word(lnk.state_word), .resume_idx(lnk.resume_idx));
    initial forever #20 clk_i = ~clk_i;
    // Block table: block 4 chains to block 5, every other block ends the sequence
    always @(posedge clk_i) next_block_i <= (act_block_o === 5'h03) ? 8'h05 : 8'h00;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Bounded poll of masked state word bits
    task automatic wait_st(input logic [15:0] m, input logic [15:0] v);
        int i;
        for (i = 0; i < 300 && (lnk.state_word & m) !== v; i++)
            @(posedge clk_i) #1;
        if (i == 300)
        begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic t_enable();
        wr(4'h4, 16'h0007);
        rd(4'hf, rd_v);
        chk(rd_v, 16'h0000);
        wr(4'h1, 16'h0006);
        rd(4'h1, rd_v);
        chk(rd_v, 16'h0000);
        wr(4'h6, 16'h0001);
        wait_st(16'hffff, 16'h0033);
        repeat (4) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wr(4'h3, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wr(4'h1, 16'h0006);
    endtask
    task automatic t_homing();
        wr(4'h0, 16'h000f);
        wait_st(16'h00ff, 16'h0037);
        wr(4'h0, 16'h001f);
        wait_st(16'h1000, 16'h1000);
        chk(lnk.state_word & 16'hf4ff, 16'h1437);
        wr(4'h0, 16'h000f);
        home_fail_i <= 1'b1;
        wr(4'h0, 16'h001f);
        wait_st(16'h2000, 16'h2000);
        home_fail_i <= 1'b0;
        wr(4'h0, 16'h000f);
        wr(4'h0, 16'h001f);
        wr(4'h0, 16'h011f);
        wait_st(16'h0400, 16'h0400);
        chk(moving_o, 1'b0);
        wr(4'h0, 16'h001f);
        repeat (4) @(posedge clk_i);
        chk(lnk.state_word[12], 1'b0);
        chk(moving_o, 1'b1);
        wr(4'h0, 16'h000f);
        repeat (2) @(posedge clk_i);
        chk(moving_o, 1'b0);
    endtask
    task automatic t_table();
        wr(4'h0, 16'h0007);
        wait_st(16'hffff, 16'h0033);
        wr(4'h1, 16'h0007);
        wr(4'h0, 16'h000f);
        wr(4'h0, 16'h1a0f);
        wait_st(16'h0100, 16'h0100);
        chk(act_block_o, 5'h03);
        wait_st(16'h0100, 16'h0000);
        wr(4'h0, 16'h181f);
        wr(4'h0, 16'h1a1f);
        repeat (40) @(posedge clk_i);
        chk(lnk.state_word[8], 1'b1);
        wait_st(16'h0100, 16'h0000);
        wr(4'h0, 16'h000f);
        wr(4'h0, 16'h0a0f);
        wait_st(16'h0100, 16'h0100);
        chk(moving_o, 1'b1);
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        ce_i <= 1'b1;
        chk(lnk.state_word[8], 1'b1);
        wr(4'h0, 16'h0b0f);
        wait_st(16'h0400, 16'h0400);
        chk(moving_o, 1'b0);
        wr(4'h0, 16'h000f);
        wait_st(16'h0100, 16'h0000);
        rd(4'h5, rd_v);
        chk(rd_v, 16'h0001);
        wr(4'h0, 16'h024f);
        wait_st(16'h0100, 16'h0100);
        chk(act_block_o, 5'h01);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_enable();
        t_homing();
        t_table();
        close_out();
    end
endmodule
